//--- rtl/bsir_pkg.sv
package bsir_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_CTRL   = 8'h01;
	localparam logic [7:0] OFF_BEVT   = 8'h10;
	localparam logic [7:0] OFF_SEVT   = 8'h11;
	localparam logic [7:0] OFF_FEVA   = 8'h12;
	localparam logic [7:0] OFF_FEVB   = 8'h13;
	localparam logic [7:0] OFF_BMSK   = 8'h14;
	localparam logic [7:0] OFF_VINS   = 8'h15;
	localparam logic [7:0] OFF_TMPS   = 8'h16;

	// ----------------------------------------------------------------
	// control field positions and reset values
	// ----------------------------------------------------------------
	localparam int         CB_RST     = 7;
	localparam int         CB_CHGEN   = 6;
	localparam int         CB_BOOST   = 5;
	localparam int         CB_FCTRY   = 4;
	localparam int         CB_THERM   = 3;
	localparam int         CB_PATH    = 2;
	localparam int         CB_TMR     = 1;
	localparam int         CB_GMASK   = 0;
	localparam logic [7:0] CTRL_RST   = 8'h55;
	localparam logic [7:0] BMSK_RST   = 8'h00;

	// event bits: boost events, status event, mask positions
	localparam int         BE_OVL     = 0;
	localparam int         BE_RNG     = 1;
	localparam int         SE_STATE   = 0;
	localparam int         MK_STATE   = 2;

	// state field codes
	localparam logic [3:0] ST_OFF     = 4'h0;
	localparam logic [3:0] ST_DONE    = 4'h6;
	localparam logic [3:0] ST_WWAIT   = 4'h8;
	localparam logic [3:0] ST_WCHG    = 4'hA;
	localparam logic [3:0] ST_BSETUP  = 4'hC;
	localparam logic [3:0] ST_BRUN    = 4'hD;
	localparam logic [3:0] ST_BFAULT  = 4'hF;

	// synchroniser lane positions
	localparam int         SY_BPIN    = 0;
	localparam int         SY_FPIN    = 1;
	localparam int         SY_BATFET  = 2;
	localparam int         SY_OVL     = 3;
	localparam int         SY_VLO     = 4;
	localparam int         SY_VHI     = 5;
	localparam int         SY_VIN     = 6;
	localparam int         SY_TMP     = 14;
	localparam int         SY_W       = 22;

	// timing
	localparam int         CLK_PERIOD_NS = 5;
	localparam int         EVT_PULSE_NS  = 100000;

	typedef enum logic [1:0] {BST_IDLE, BST_SETUP, BST_RUN, BST_FAULT} bsir_bst_t;

	typedef struct packed {
		logic [SY_W-1:0] s1;
		logic [SY_W-1:0] s2;
		logic [7:0]      ctrl;
		bsir_bst_t       bst;
		logic [3:0]      prev;
		logic [7:0]      se;
		logic [7:0]      be;
		logic [7:0]      fa;
		logic [7:0]      fb;
		logic [7:0]      msk;
		logic [7:0]      rdata;
		logic            srst;
		logic            fired;
		logic            pulse;
		logic [15:0]     cnt;
	} bsir_q_t;
endpackage

//--- rtl/bsir_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - overload in unconfigured boost sets indication bit
// - battery out of range stops boost, flags
// - restart only after request toggles off
// - state field encodes charge states 0000..1011
// - boost states report 1100, 1101, 1111
// - charger fault events held cleared in boost
// - state change pulses event pin, low in boost
// - transitions and boost events interrupt unless masked
// - event bits clear when read
// - one pulse until events fully cleared
// - sense registers show live comparator levels
// - status bit1 summarises status events
// - status bit0 summarises fault and boost events
// - status bit3 shows isolation transistor present
// - control bit7 write resets all registers
// - bit6 enables charging, zero stops boost
// - bit5 requests boost, clears on charge entry
// - bit4 resets to one, reloads on boost
// - bit3 enables thermal charge current derating
// - bit2 selects limited or low-resistance path
// - bit1 restarts charge timer, self clears
// - bit0 global mask blocks event pin
// - factory mode when pin equals setting bit
module bsir_regs
	import bsir_pkg::*;
#(
	parameter int unsigned PULSE_CYC = EVT_PULSE_NS / CLK_PERIOD_NS
) (
	input  wire logic       core_clk,          // device clock
	input  wire logic       rst,               // sync reset, high
	input  wire logic [7:0] reg_addr,          // register address
	input  wire logic       reg_wr,            // write strobe
	input  wire logic       reg_rd,            // read strobe
	input  wire logic [7:0] reg_wdata,         // write data
	output logic      [7:0] reg_rdata,         // read data, next cycle
	input  wire logic [3:0] charge_state,      // charger state code
	input  wire logic       charge_mode_enter, // charge mode entry pulse
	input  wire logic       power_off,         // device off state
	input  wire logic       setup_done,        // boost start-up finished
	input  wire logic [7:0] fault_a_set,       // charger fault events a
	input  wire logic [7:0] fault_b_set,       // charger fault events b
	input  wire logic       boost_request_pin, // external boost request
	input  wire logic       factory_pin,       // factory strap pin
	input  wire logic       batfet_detect,     // isolation fet present
	input  wire logic       overload_cmp,      // load above precharge source
	input  wire logic       vbat_low_cmp,      // battery under threshold
	input  wire logic       vbat_high_cmp,     // battery over threshold
	input  wire logic [7:0] vin_cmp,           // input comparators
	input  wire logic [7:0] temp_cmp,          // thermal comparators
	output logic            event_pin,         // event pin level
	output logic            boost_on,          // boost converter enable
	output logic            charging_allow,    // charging enabled
	output logic            thermal_derate,    // thermal current derate
	output logic            path_low_res,      // low-resistance path
	output logic            timer_restart,     // charge timer restart pulse
	output logic            factory_active     // factory mode active
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	localparam bsir_q_t Q_RST = '{ctrl: CTRL_RST, msk: BMSK_RST, bst: BST_IDLE, default: '0};

	// address match, used by the write and read-clear decodes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// charger active or wait states hold the pin low
	function automatic logic chg_active(input logic [3:0] s);
		return (s != ST_OFF && s <= ST_DONE) || (s >= ST_WWAIT && s <= ST_WCHG);
	endfunction

	bsir_q_t    q;
	bsir_q_t    d;
	logic [3:0] sf;
	logic [7:0] stat_val;
	logic       req;
	logic       rng;
	logic       pending;
	logic       all_clear;
	logic       start;
	logic       bmode;
	logic       any_se;
	logic       any_flt;

	// ----------------------------------------------------------------
	// status view
	// ----------------------------------------------------------------
	assign bmode = q.bst != BST_IDLE;
	assign req   = q.ctrl[CB_BOOST] | q.s2[SY_BPIN];
	assign rng   = q.s2[SY_VLO] | q.s2[SY_VHI];

	// state field, boost codes override charger codes
	always_comb begin
		case (q.bst)
			BST_SETUP: sf = ST_BSETUP;
			BST_RUN:   sf = ST_BRUN;
			BST_FAULT: sf = ST_BFAULT;
			default:   sf = charge_state;
		endcase
	end

	// summary bits follow the event registers directly
	assign stat_val = {sf, q.s2[SY_BATFET], 1'b0,
		|q.se,
		|q.fa | |q.fb | |q.be};

	// interrupt request terms
	assign pending   = |(q.be[BE_RNG:BE_OVL] & ~q.msk[BE_RNG:BE_OVL])
		| (q.se[SE_STATE] & ~q.msk[MK_STATE]) | |q.fa | |q.fb;
	assign all_clear = ~(|q.se | |q.be | |q.fa | |q.fb);

	// summary terms kept as plain signals so checks can look back at them
	assign any_se    = |q.se;
	assign any_flt   = |q.be | |q.fa | |q.fb;
	assign start     = pending & ~q.fired & ~q.ctrl[CB_GMASK] & ~q.pulse;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.s1 = {temp_cmp, vin_cmp, vbat_high_cmp, vbat_low_cmp, overload_cmp,
			batfet_detect, factory_pin, boost_request_pin};
		d.s2 = q.s1;
		d.srst = 1'b0;
		d.ctrl[CB_TMR] = 1'b0;
		// register writes
		if (reg_wr && hit(reg_addr, OFF_CTRL)) begin
			d.ctrl = {1'b0, reg_wdata[6:0]};
			d.srst = reg_wdata[CB_RST];
		end
		if (reg_wr && hit(reg_addr, OFF_BMSK)) begin
			d.msk = reg_wdata;
		end
		if (charge_mode_enter) begin
			d.ctrl[CB_BOOST] = 1'b0;
		end
		// boost sequencing
		case (q.bst)
			BST_IDLE: begin
				if (req && q.ctrl[CB_CHGEN]) begin
					d.bst = BST_SETUP;
					d.ctrl[CB_FCTRY] = CTRL_RST[CB_FCTRY];
				end
			end
			BST_SETUP, BST_RUN: begin
				if (!req || !q.ctrl[CB_CHGEN]) begin
					d.bst = BST_IDLE;
				end else if (rng) begin
					d.bst = BST_FAULT;
				end else if (setup_done) begin
					d.bst = BST_RUN;
				end
			end
			BST_FAULT: begin
				if (!req) begin
					d.bst = BST_IDLE;
				end
			end
			default: d.bst = BST_IDLE;
		endcase
		// event registers, set wins over read clear
		d.be = q.be & ~{8{reg_rd && hit(reg_addr, OFF_BEVT)}};
		d.se = q.se & ~{8{reg_rd && hit(reg_addr, OFF_SEVT)}};
		d.fa = (q.fa & ~{8{reg_rd && hit(reg_addr, OFF_FEVA)}}) | fault_a_set;
		d.fb = (q.fb & ~{8{reg_rd && hit(reg_addr, OFF_FEVB)}}) | fault_b_set;
		if (bmode && !q.ctrl[CB_PATH] && q.s2[SY_OVL]) begin
			d.be[BE_OVL] = 1'b1;
		end
		if ((q.bst == BST_SETUP || q.bst == BST_RUN) && req && q.ctrl[CB_CHGEN] && rng) begin
			d.be[BE_RNG] = 1'b1;
		end
		if (sf != q.prev) begin
			d.se[SE_STATE] = 1'b1;
		end
		d.prev = sf;
		if (bmode) begin
			d.fa = '0;
			d.fb = '0;
		end
		// read data
		if (reg_rd) begin
			case (reg_addr)
				OFF_STATUS: d.rdata = stat_val;
				OFF_CTRL:   d.rdata = q.ctrl;
				OFF_BEVT:   d.rdata = q.be;
				OFF_SEVT:   d.rdata = q.se;
				OFF_FEVA:   d.rdata = q.fa;
				OFF_FEVB:   d.rdata = q.fb;
				OFF_BMSK:   d.rdata = q.msk;
				OFF_VINS:   d.rdata = q.s2[SY_VIN +: 8];
				OFF_TMPS:   d.rdata = q.s2[SY_TMP +: 8];
				default:    d.rdata = 8'h00;
			endcase
		end
		// event pulse timing
		if (start) begin
			d.pulse = 1'b1;
			d.fired = 1'b1;
			d.cnt = 16'(PULSE_CYC - 1);
		end else if (q.pulse) begin
			if (q.cnt == 16'h0000) begin
				d.pulse = 1'b0;
			end else begin
				d.cnt = q.cnt - 16'h0001;
			end
		end
		if (all_clear && !start) begin
			d.fired = 1'b0;
		end
		// soft register reset and off state
		if (q.srst || power_off) begin
			d = Q_RST;
			d.s1 = q.s1;
			d.s2 = q.s2;
			d.prev = sf;
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= Q_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata      = q.rdata;
	assign event_pin      = (bmode | ~chg_active(sf)) ^ q.pulse;
	assign boost_on       = q.bst == BST_SETUP || q.bst == BST_RUN;
	assign charging_allow = q.ctrl[CB_CHGEN];
	assign thermal_derate = q.ctrl[CB_THERM];
	assign path_low_res   = q.ctrl[CB_PATH];
	assign timer_restart  = q.ctrl[CB_TMR];
	assign factory_active = q.s2[SY_FPIN] == q.ctrl[CB_FCTRY];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_pulse_rise;
		$rose(q.pulse);
	endsequence
	sequence s_pulse_hold;
		q.pulse[*8];
	endsequence
	sequence s_stat_read;
		reg_rd && hit(reg_addr, OFF_STATUS);
	endsequence
	sequence s_sevt_quiet_read;
		reg_rd && hit(reg_addr, OFF_SEVT) && (sf == q.prev);
	endsequence

	AST_RNG_STOP: assert property ((q.bst == BST_RUN) && rng && req && q.ctrl[CB_CHGEN]
		&& !q.srst && !power_off |=> q.bst == BST_FAULT && q.be[BE_RNG] && !boost_on)
		else $error("range fault did not stop boost");
	AST_NO_RESTART: assert property ((q.bst == BST_FAULT) && req && !q.srst && !power_off
		|=> q.bst == BST_FAULT)
		else $error("boost left fault without toggle");
	AST_RUN_CODE: assert property ((q.bst == BST_RUN) && reg_rd && hit(reg_addr, OFF_STATUS)
		|=> reg_rdata[7:4] == ST_BRUN)
		else $error("run state code wrong");
	AST_CHG_HOLD: assert property ($past(bmode) && !$past(q.srst) |-> q.fa == 8'h00)
		else $error("charger fault events active in boost");
	AST_PULSE_LEN: assert property (s_pulse_rise |-> s_pulse_hold)
		else $error("event pulse too short");
	AST_BOOST_LOW: assert property (q.pulse && bmode |-> !event_pin)
		else $error("boost pulse not low");
	AST_ONE_PULSE: assert property (q.fired && !all_clear |=> !$rose(q.pulse))
		else $error("second pulse before events cleared");
	AST_GMASK: assert property (q.ctrl[CB_GMASK] && !q.pulse |=> !q.pulse)
		else $error("pulse despite global mask");
	AST_SOFT_RST: assert property (reg_wr && hit(reg_addr, OFF_CTRL) && reg_wdata[CB_RST]
		|=> ##1 q.ctrl == CTRL_RST && q.be == 8'h00)
		else $error("register reset not applied");
	AST_TMR_CLR: assert property (timer_restart |=> !timer_restart)
		else $error("timer restart not self clearing");
	AST_SUM_BIT: assert property (s_stat_read
		|=> reg_rdata[1] == $past(any_se) && reg_rdata[0] == $past(any_flt))
		else $error("summary bits wrong");
	// a read with no new state change must leave the status events empty
	AST_READ_CLR: assert property (s_sevt_quiet_read |=> q.se == 8'h00)
		else $error("status events not cleared by read");
	// overload in unconfigured boost must be flagged the next cycle
	AST_OVL_SET: assert property (bmode && !q.ctrl[CB_PATH] && q.s2[SY_OVL]
		&& !q.srst && !power_off |=> q.be[BE_OVL])
		else $error("overload indication not set");

endmodule
`default_nettype wire

//--- test/bsir_host.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------------------
// host processor model
// --------------------------------
module bsir_host
	import bsir_pkg::*;
(
	input  wire logic       core_clk,  // device clock
	output logic      [7:0] reg_addr,  // register address
	output logic            reg_wr,    // write strobe
	output logic            reg_rd,    // read strobe
	output logic      [7:0] reg_wdata, // write data
	input  wire logic [7:0] reg_rdata, // read data
	input  wire logic       event_pin  // event pin level
);
	int low_cnt;
	// idle bus, strobes low
	initial begin
		reg_addr  = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_wdata = 8'h00;
		low_cnt   = 0;
	end
	// count cycles the event pin sits low
	always @(posedge core_clk) begin
		if (event_pin === 1'b0) begin
			low_cnt <= low_cnt + 1;
		end
	end
	// one write, data line flipped once released
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~v;
	endtask
	// one read, data taken a cycle after the read edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		v = reg_rdata;
	endtask
	// drop then raise the boost request to leave a fault
	task automatic boost_retry(input logic [7:0] c);
		wr(OFF_CTRL, c & 8'hDF);
		wr(OFF_CTRL, c);
	endtask
endmodule
`default_nettype wire

//--- test/boost_status_interrupt_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module boost_status_interrupt_regs_bench
	import bsir_pkg::*;
;
	logic       core_clk, rst, reg_wr, reg_rd, cme, power_off, setup_done;
	logic       bpin, factory_pin, batfet_detect, ovl, vlo, vhi;
	logic       event_pin, boost_on, chg, therm, path, tmr, fact;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, fa, fb, vin, tmp, d;
	logic [3:0] charge_state;
	int         err_total, n_compared, cycles;
	// --------------------------------
	// design and host
	// --------------------------------
	bsir_regs #(.PULSE_CYC(16)) u_bsir_regs (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.charge_state(charge_state), .charge_mode_enter(cme), .power_off(power_off),
		.setup_done(setup_done), .fault_a_set(fa), .fault_b_set(fb),
		.boost_request_pin(bpin), .factory_pin(factory_pin),
		.batfet_detect(batfet_detect), .overload_cmp(ovl), .vbat_low_cmp(vlo),
		.vbat_high_cmp(vhi), .vin_cmp(vin), .temp_cmp(tmp), .event_pin(event_pin),
		.boost_on(boost_on), .charging_allow(chg), .thermal_derate(therm),
		.path_low_res(path), .timer_restart(tmr), .factory_active(fact)
	);
	bsir_host u_bsir_host (
		.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_pin(event_pin)
	);
	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic [7:0] st_exp(input logic [3:0] c, input logic b);
		return {c, b, 3'b000};
	endfunction
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// low cycles on the event pin over a 40 cycle window
	task automatic pulses(input string n, input int e);
		int b;
		b = u_bsir_host.low_cnt;
		cyc(40);
		chk(n, 8'(u_bsir_host.low_cnt - b), 8'(e));
	endtask
	task automatic clr;
		for (int a = 16; a < 20; a++) begin
			u_bsir_host.rd(8'(a), d);
		end
	endtask
	// clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			results;
		end
	end
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		void'($urandom(77));
		{rst, reg_wr, reg_rd} = 3'b100;
		{cme, power_off, setup_done, bpin, batfet_detect, ovl, vlo, vhi} = 8'h00;
		{fa, fb, vin, tmp, charge_state} = 36'h0_0000_0000;
		factory_pin = 1'($urandom);
		{err_total, n_compared, cycles} = 0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		u_bsir_host.rd(OFF_CTRL, d);
		chk("ctrl_rst", d, CTRL_RST);
		u_bsir_host.wr(OFF_CTRL, 8'h57);
		#1;
		chk("tmr", {7'h0, tmr}, 8'h01);
		cyc(1);
		chk("tmr_end", {7'h0, tmr}, 8'h00);
		u_bsir_host.rd(OFF_CTRL, d);
		chk("tmr_clr", d, 8'h55);
		for (int c = 0; c < 12; c++) begin
			@(posedge core_clk);
			charge_state <= 4'(c);
			batfet_detect <= 1'($urandom);
			cyc(4);
			u_bsir_host.rd(OFF_STATUS, d);
			chk("state", d & 8'hF8, st_exp(4'(c), batfet_detect));
		end
		repeat (3) begin
			@(posedge core_clk);
			vin <= 8'($urandom);
			tmp <= 8'($urandom);
			cyc(4);
			u_bsir_host.rd(OFF_VINS, d);
			chk("vin", d, vin);
			u_bsir_host.rd(OFF_TMPS, d);
			chk("tmp", d, tmp);
		end
		// event pulse outside boost
		clr;
		u_bsir_host.wr(OFF_CTRL, 8'h54);
		@(posedge core_clk);
		charge_state <= ST_OFF;
		pulses("pulse", 16);
		@(posedge core_clk);
		charge_state <= 4'h7;
		pulses("one_pulse", 0);
		u_bsir_host.rd(OFF_STATUS, d);
		chk("sum_set", d & 8'h03, 8'h02);
		clr;
		u_bsir_host.rd(OFF_STATUS, d);
		chk("sum_clr", d & 8'h03, 8'h00);
		@(posedge core_clk);
		charge_state <= ST_OFF;
		pulses("re_pulse", 16);
		// boost entry with state events masked
		clr;
		u_bsir_host.wr(OFF_BMSK, 8'h04);
		u_bsir_host.wr(OFF_CTRL, 8'h74);
		pulses("masked", 0);
		chk("boost_on", {7'h0, boost_on}, 8'h01);
		u_bsir_host.rd(OFF_STATUS, d);
		chk("setup", d & 8'hF0, {ST_BSETUP, 4'h0});
		@(posedge core_clk);
		setup_done <= 1'b1;
		cyc(4);
		u_bsir_host.rd(OFF_STATUS, d);
		chk("run", d & 8'hF0, {ST_BRUN, 4'h0});
		clr;
		u_bsir_host.wr(OFF_BMSK, 8'h00);
		@(posedge core_clk);
		fa <= 8'h01;
		@(posedge core_clk);
		fa <= 8'h00;
		vlo <= 1'b1;
		pulses("boost_pulse", 16);
		chk("boost_off", {7'h0, boost_on}, 8'h00);
		u_bsir_host.rd(OFF_STATUS, d);
		chk("bfault", d & 8'hF1, {ST_BFAULT, 4'h1});
		@(posedge core_clk);
		vlo <= 1'b0;
		cyc(6);
		u_bsir_host.rd(OFF_BEVT, d);
		chk("bevt", d, 8'h02);
		u_bsir_host.rd(OFF_BEVT, d);
		chk("bevt_clr", d, 8'h00);
		u_bsir_host.rd(OFF_FEVA, d);
		chk("fev_held", d, 8'h00);
		u_bsir_host.rd(OFF_STATUS, d);
		chk("stay", d & 8'hF0, {ST_BFAULT, 4'h0});
		u_bsir_host.boost_retry(8'h64);
		cyc(4);
		u_bsir_host.rd(OFF_CTRL, d);
		chk("fct_reload", d, 8'h74);
		u_bsir_host.rd(OFF_STATUS, d);
		chk("restart", d & 8'hF0, {ST_BRUN, 4'h0});
		// overload in unconfigured boost
		u_bsir_host.wr(OFF_CTRL, 8'h70);
		clr;
		chk("path", {7'h0, path}, 8'h00);
		@(posedge core_clk);
		ovl <= 1'b1;
		cyc(6);
		u_bsir_host.rd(OFF_BEVT, d);
		chk("ovl", d, 8'h01);
		@(posedge core_clk);
		cme <= 1'b1;
		ovl <= 1'b0;
		@(posedge core_clk);
		cme <= 1'b0;
		cyc(3);
		u_bsir_host.rd(OFF_CTRL, d);
		chk("req_clr", d & 8'h20, 8'h00);
		u_bsir_host.wr(OFF_CTRL, 8'h59);
		cyc(2);
		chk("therm", {6'h0, therm, chg}, 8'h03);
		chk("fct_on", {7'h0, fact}, {7'h0, factory_pin});
		u_bsir_host.wr(OFF_CTRL, 8'h09);
		cyc(2);
		chk("chg_off", {7'h0, chg}, 8'h00);
		chk("fct_off", {7'h0, fact}, {7'h0, ~factory_pin});
		// soft reset and unmapped read
		u_bsir_host.wr(OFF_BMSK, 8'h07);
		u_bsir_host.wr(OFF_CTRL, 8'h80);
		cyc(3);
		u_bsir_host.rd(OFF_CTRL, d);
		chk("srst_ctrl", d, CTRL_RST);
		u_bsir_host.rd(OFF_BMSK, d);
		chk("srst_msk", d, BMSK_RST);
		u_bsir_host.rd(8'h20, d);
		chk("unmapped", d, 8'h00);
		results;
	end
endmodule
`default_nettype wire
